// [verilog/i2c_slave_port.v]
// Byte-level I2C target port with polled status flags.
// Assumes an external master drives the clock line, pull-ups on both
// lines, and software that polls the flags and strobes data accesses.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_slave_port_defs.vh"

module i2c_slave_port
(
   input wire core_clk,
   input wire rstn,
   input wire serial_bus_enable,
   input wire general_call_enable,
   input wire power_down,
   input wire pullup_in_ctrl_clk,
   input wire pullup_out_ctrl_clk,
   input wire pullup_in_ctrl_dat,
   input wire pullup_out_ctrl_dat,
   output wire pullup_en_clk,
   output wire pullup_en_dat,
   input wire sw_dir_out_clk,
   input wire sw_level_clk,
   input wire sw_dir_out_dat,
   input wire sw_level_dat,
   input wire port_pin_clock_i,
   output wire port_pin_clock_o,
   output wire port_pin_clock_oe_n,
   input wire port_pin_data_i,
   output wire port_pin_data_o,
   output wire port_pin_data_oe_n,
   input wire [7:0] bus_data_wdata,
   input wire bus_data_wr,
   input wire bus_data_rd,
   output wire [7:0] bus_data_reg,
   input wire flag_clear,
   output wire addr_match_flag,
   output wire rx_buffer_full_flag,
   output wire read_dir_flag,
   output wire tx_buffer_full_flag,
   output wire stop_flag,
   output wire overflow_flag
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ADDR_ACK = 3'h2;
   localparam [2:0] ST_RX = 3'h3;
   localparam [2:0] ST_RX_ACK = 3'h4;
   localparam [2:0] ST_TX = 3'h5;
   localparam [2:0] ST_TX_ACK = 3'h6;
   localparam [2:0] ST_IGNORE = 3'h7;
   localparam [7:0] OWN_ADDR = `OWN_ADDR_BYTE;

   // Shift one sampled bus bit in at the bottom, MSB first on the wire
   function [7:0] shift_in;
      input [7:0] value;
      input bit_in;
      begin
         shift_in = {value[6:0], bit_in};
      end
   endfunction

   wire [1:0] pins_sync;
   wire scl_s;
   wire sda_s;
   wire active;
   wire scl_rise;
   wire scl_fall;
   wire start_seen;
   wire stop_seen;
   wire byte_done;
   wire addr_ok;
   wire gc_ok;

   reg scl_q;
   reg sda_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg [7:0] shift_q;
   reg [7:0] shift_d;
   reg drive_low_q;
   reg drive_low_d;
   reg [7:0] rx_data_q;
   reg [7:0] tx_buf_q;
   reg rbf_q;
   reg tbf_q;
   reg am_q;
   reg rnw_q;
   reg stop_q;
   reg ovf_q;
   reg rx_load;
   reg tx_take;
   reg am_set;
   reg rnw_set;

   pin_sync u_pin_sync
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in({port_pin_clock_i, port_pin_data_i}),
      .pin_sync_out(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   assign active = serial_bus_enable & ~power_down;

   assign pullup_en_clk = pullup_in_ctrl_clk & pullup_out_ctrl_clk;
   assign pullup_en_dat = pullup_in_ctrl_dat & pullup_out_ctrl_dat;

   // While active the clock pin is only ever an input: no clock stretching
   assign port_pin_clock_oe_n = active ? 1'b1 : ~sw_dir_out_clk;
   assign port_pin_clock_o = active ? 1'b0 : sw_level_clk;
   // While active the data pin drives only a low level; a one is a released line
   assign port_pin_data_oe_n = active ? ~drive_low_q : ~sw_dir_out_dat;
   assign port_pin_data_o = active ? 1'b0 : sw_level_dat;

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;
   assign byte_done = (cnt_q == `BITS_PER_BYTE);
   assign addr_ok = (shift_q[7:1] == OWN_ADDR[7:1]);
   assign gc_ok = general_call_enable & (shift_q == `GEN_CALL_BYTE);

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   always @*
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      drive_low_d = drive_low_q;
      rx_load = 1'b0;
      tx_take = 1'b0;
      am_set = 1'b0;
      rnw_set = 1'b0;
      if (!active)
      begin
         state_d = ST_IDLE;
         cnt_d = `RESET_CNT;
         drive_low_d = 1'b0;
      end
      else if (start_seen)
      begin
         // Repeated start is handled like a first start
         state_d = ST_ADDR;
         cnt_d = `RESET_CNT;
         drive_low_d = 1'b0;
      end
      else if (stop_seen)
      begin
         state_d = ST_IDLE;
         cnt_d = `RESET_CNT;
         drive_low_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               drive_low_d = 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise && !byte_done)
               begin
                  shift_d = shift_in(shift_q, sda_s);
                  cnt_d = cnt_q + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  cnt_d = `RESET_CNT;
                  if (addr_ok || gc_ok)
                  begin
                     drive_low_d = 1'b1;
                     am_set = 1'b1;
                     rnw_set = addr_ok & shift_q[`RNW_BIT];
                     state_d = ST_ADDR_ACK;
                  end
                  else
                  begin
                     state_d = ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (rnw_q)
                  begin
                     tx_take = 1'b1;
                     shift_d = tbf_q ? tx_buf_q : `TX_IDLE_BYTE;
                     drive_low_d = tbf_q ? ~tx_buf_q[7] : 1'b0;
                     state_d = ST_TX;
                  end
                  else
                  begin
                     drive_low_d = 1'b0;
                     state_d = ST_RX;
                  end
               end
            end
            ST_RX:
            begin
               if (scl_rise && !byte_done)
               begin
                  shift_d = shift_in(shift_q, sda_s);
                  cnt_d = cnt_q + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  cnt_d = `RESET_CNT;
                  rx_load = 1'b1;
                  drive_low_d = 1'b1;
                  state_d = ST_RX_ACK;
               end
            end
            ST_RX_ACK:
            begin
               if (scl_fall)
               begin
                  drive_low_d = 1'b0;
                  state_d = ST_RX;
               end
            end
            ST_TX:
            begin
               if (scl_rise && !byte_done)
               begin
                  cnt_d = cnt_q + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  cnt_d = `RESET_CNT;
                  drive_low_d = 1'b0;
                  state_d = ST_TX_ACK;
               end
               else if (scl_fall)
               begin
                  shift_d = shift_in(shift_q, 1'b1);
                  drive_low_d = ~shift_q[6];
               end
            end
            ST_TX_ACK:
            begin
               // A master that does not acknowledge ends the read
               if (scl_rise && sda_s)
               begin
                  state_d = ST_IGNORE;
               end
               else if (scl_fall)
               begin
                  tx_take = 1'b1;
                  shift_d = tbf_q ? tx_buf_q : `TX_IDLE_BYTE;
                  drive_low_d = tbf_q ? ~tx_buf_q[7] : 1'b0;
                  state_d = ST_TX;
               end
            end
            ST_IGNORE:
            begin
               drive_low_d = 1'b0;
            end
            default:
            begin
               state_d = ST_IDLE;
               drive_low_d = 1'b0;
            end
         endcase
      end
   end

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= `RESET_CNT;
         shift_q <= `RESET_BYTE;
         drive_low_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         drive_low_q <= drive_low_d;
      end
   end

   // Flags: hardware set wins over a clear in the same cycle
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_data_q <= `RESET_BYTE;
         tx_buf_q <= `RESET_BYTE;
         rbf_q <= 1'b0;
         tbf_q <= 1'b0;
         am_q <= 1'b0;
         rnw_q <= 1'b0;
         stop_q <= 1'b0;
         ovf_q <= 1'b0;
      end
      else
      begin
         // A late byte overwrites the unread one; overflow tells software
         if (rx_load)
         begin
            rx_data_q <= shift_q;
         end
         if (rx_load)
         begin
            rbf_q <= 1'b1;
         end
         else if (bus_data_rd)
         begin
            rbf_q <= 1'b0;
         end
         if (bus_data_wr && !tbf_q)
         begin
            tx_buf_q <= bus_data_wdata;
         end
         if (bus_data_wr && !tbf_q)
         begin
            tbf_q <= 1'b1;
         end
         else if (tx_take)
         begin
            tbf_q <= 1'b0;
         end
         if (am_set)
         begin
            am_q <= 1'b1;
         end
         else if (flag_clear)
         begin
            am_q <= 1'b0;
         end
         if (am_set)
         begin
            rnw_q <= rnw_set;
         end
         if (stop_seen && active)
         begin
            stop_q <= 1'b1;
         end
         else if (flag_clear)
         begin
            stop_q <= 1'b0;
         end
         if ((rx_load && rbf_q && !bus_data_rd) || (bus_data_wr && tbf_q))
         begin
            ovf_q <= 1'b1;
         end
         else if (flag_clear)
         begin
            ovf_q <= 1'b0;
         end
      end
   end

   assign bus_data_reg = rx_data_q;
   assign addr_match_flag = am_q;
   assign rx_buffer_full_flag = rbf_q;
   assign read_dir_flag = rnw_q;
   assign tx_buffer_full_flag = tbf_q;
   assign stop_flag = stop_q;
   assign overflow_flag = ovf_q;

endmodule // i2c_slave_port

`default_nettype wire

// [verilog/i2c_slave_port_defs.vh]
// Constants for the byte-level I2C target port.
// Included by the port logic; holds definitions only.
`ifndef I2C_SLAVE_PORT_DEFS_VH
`define I2C_SLAVE_PORT_DEFS_VH

// Own address byte as it appears on the wire with the direction bit clear
`define OWN_ADDR_BYTE 8'h6C
// General call address byte
`define GEN_CALL_BYTE 8'h00
// Direction bit position inside the address byte
`define RNW_BIT 0
// Bits per byte on the wire
`define BITS_PER_BYTE 4'h8
// Idle value shifted out when no transmit byte is waiting
`define TX_IDLE_BYTE 8'hFF
// Reset values
`define RESET_BYTE 8'h00
`define RESET_CNT 4'h0
// Synchroniser depth for pins
`define SYNC_STAGES 2

`endif

// [verilog/pin_sync.v]
// Two-flop synchroniser for the two bus pins.
// Inputs come from pins outside the core_clk domain.
`timescale 1ns/100ps
`default_nettype none

module pin_sync
(
   input wire core_clk,
   input wire rstn,
   input wire [1:0] pin_in,
   output wire [1:0] pin_sync_out
);

   // Pins idle high through the pull-ups, so reset to one avoids a
   // false start or stop right after reset
   reg [1:0] meta_q;
   reg [1:0] sync_q;

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= 2'h3;
         sync_q <= 2'h3;
      end
      else
      begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_sync_out = sync_q;

endmodule // pin_sync

`default_nettype wire

// [verilog/unused_placeholder_none.v]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [dv/i2c_slave_port_properties.sv]
// Assertions on the I2C target port, bound to its top module.
// Sees port signals only; bus pins carry the resolved line levels.
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_port_chk
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic serial_bus_enable,
   input wire logic power_down,
   input wire logic pullup_in_ctrl_clk,
   input wire logic pullup_out_ctrl_clk,
   input wire logic pullup_in_ctrl_dat,
   input wire logic pullup_out_ctrl_dat,
   input wire logic pullup_en_clk,
   input wire logic pullup_en_dat,
   input wire logic sw_dir_out_dat,
   input wire logic sw_level_dat,
   input wire logic port_pin_clock_i,
   input wire logic port_pin_clock_oe_n,
   input wire logic port_pin_data_i,
   input wire logic port_pin_data_o,
   input wire logic port_pin_data_oe_n,
   input wire logic bus_data_wr,
   input wire logic bus_data_rd,
   input wire logic addr_match_flag,
   input wire logic rx_buffer_full_flag,
   input wire logic read_dir_flag,
   input wire logic tx_buffer_full_flag,
   input wire logic stop_flag,
   input wire logic overflow_flag
);
   wire logic act = serial_bus_enable & ~power_down;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_stop;
      act && port_pin_clock_i && $rose(port_pin_data_i);
   endsequence
   // Enable edges are excluded: the pin hands over between owners there
   sequence s_sda_move;
      act && $past(act) && $changed(port_pin_data_oe_n);
   endsequence
   property p_pullup;
      pullup_en_clk == (pullup_in_ctrl_clk & pullup_out_ctrl_clk) &&
      pullup_en_dat == (pullup_in_ctrl_dat & pullup_out_ctrl_dat);
   endproperty
   property p_sw_pins;
      !act |-> port_pin_data_oe_n == ~sw_dir_out_dat &&
         port_pin_data_o == sw_level_dat;
   endproperty
   property p_scl_in;
      act |-> port_pin_clock_oe_n;
   endproperty
   property p_pull;
      act && !port_pin_data_oe_n |-> !port_pin_data_o;
   endproperty
   property p_sda;
      s_sda_move |-> !port_pin_clock_i;
   endproperty
   property p_rd_clr;
      bus_data_rd |=> !rx_buffer_full_flag;
   endproperty
   property p_tbf;
      bus_data_wr && !tx_buffer_full_flag |=> tx_buffer_full_flag;
   endproperty
   property p_ovf;
      bus_data_wr && tx_buffer_full_flag |=> overflow_flag;
   endproperty
   property p_stop;
      s_stop |-> ##[1:8] stop_flag;
   endproperty
   property p_rnw;
      $rose(read_dir_flag) |-> addr_match_flag;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("pull-up enable wrong");
   a_sw_pins: assert property (p_sw_pins)
      else $error("data pin not under software control");
   a_scl_in: assert property (p_scl_in)
      else $error("clock pin driven while active");
   a_pull: assert property (p_pull)
      else $error("data pin driven high");
   a_sda: assert property (p_sda)
      else $error("data drive moved while clock high");
   a_rd_clr: assert property (p_rd_clr)
      else $error("receive full not cleared by read");
   a_tbf: assert property (p_tbf)
      else $error("transmit full not set by write");
   a_ovf: assert property (p_ovf)
      else $error("overflow not set by early write");
   a_stop: assert property (p_stop)
      else $error("stop flag missing");
   a_rnw: assert property (p_rnw)
      else $error("read flag without address match");
endmodule // i2c_slave_port_chk
bind i2c_slave_port i2c_slave_port_chk chk_u
(
   .core_clk, .rstn, .serial_bus_enable, .power_down, .pullup_in_ctrl_clk,
   .pullup_out_ctrl_clk, .pullup_in_ctrl_dat, .pullup_out_ctrl_dat,
   .pullup_en_clk, .pullup_en_dat, .sw_dir_out_dat, .sw_level_dat,
   .port_pin_clock_i, .port_pin_clock_oe_n, .port_pin_data_i,
   .port_pin_data_o, .port_pin_data_oe_n, .bus_data_wr, .bus_data_rd,
   .addr_match_flag, .rx_buffer_full_flag, .read_dir_flag,
   .tx_buffer_full_flag, .stop_flag, .overflow_flag
);
`default_nettype wire

// [dv/i2c_master_model.sv]
// Bus master model: drives SCL and pulls SDA, 125 ns bit period.
// The bench resolves both lines with pull-ups; SCL stands still when idle.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model
(
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Data moves mid-way through SCL low so it is stable while SCL is high
   task automatic put_bit(input logic b, output logic r);
      #30 sda_low = ~b;
      #32.5 scl_low = 1'b0;
      #31.25 r = sda;
      #31.25 scl_low = 1'b1;
   endtask
   task automatic start_cond();
      if (scl_low)
      begin
         #30 sda_low = 1'b0;
         #32.5 scl_low = 1'b0;
      end
      #62.5 sda_low = 1'b1;
      #62.5 scl_low = 1'b1;
   endtask
   task automatic stop_cond();
      #30 sda_low = 1'b1;
      #32.5 scl_low = 1'b0;
      #62.5 sda_low = 1'b0;
   endtask
   // Eight bits MSB first, then the ninth clock
   task automatic xfer(input logic [7:0] d, input logic ack_out,
      output logic [7:0] q, output logic ack_in);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         put_bit(d[i], r);
         q[i] = r;
      end
      put_bit(~ack_out, r);
      ack_in = ~r;
   endtask
endmodule // i2c_master_model
`default_nettype wire

// [dv/tb_i2c_slave_port.sv]
// Self-checking bench for the I2C target port with a bus master model.
// Assumes pull-ups on both lines and software strobes from this bench.
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_slave_port;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic serial_bus_enable = 1'b0;
   logic general_call_enable = 1'b0;
   logic power_down = 1'b0;
   logic [3:0] pu = 4'h0;
   logic [3:0] sw = 4'h0;
   logic [2:0] stb = 3'h0;
   logic [7:0] bus_data_wdata = 8'h00;
   wire logic pullup_en_clk, pullup_en_dat, port_pin_clock_o, scl_low;
   wire logic port_pin_clock_oe_n, port_pin_data_o, port_pin_data_oe_n;
   wire logic addr_match_flag, rx_buffer_full_flag, read_dir_flag, sda_low;
   wire logic tx_buffer_full_flag, stop_flag, overflow_flag;
   wire logic [7:0] bus_data_reg;
   wire logic port_pin_clock_i = ~scl_low &
      (port_pin_clock_oe_n | port_pin_clock_o);
   wire logic port_pin_data_i = ~sda_low &
      (port_pin_data_oe_n | port_pin_data_o);
   int fail_count = 0;
   int checked = 0;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   i2c_slave_port dut_u
   (
      .core_clk, .rstn, .serial_bus_enable, .general_call_enable, .power_down,
      .pullup_in_ctrl_clk(pu[0]), .pullup_out_ctrl_clk(pu[1]),
      .pullup_in_ctrl_dat(pu[2]), .pullup_out_ctrl_dat(pu[3]),
      .pullup_en_clk, .pullup_en_dat, .sw_dir_out_clk(sw[0]),
      .sw_level_clk(sw[1]), .sw_dir_out_dat(sw[2]), .sw_level_dat(sw[3]),
      .port_pin_clock_i, .port_pin_clock_o, .port_pin_clock_oe_n,
      .port_pin_data_i, .port_pin_data_o, .port_pin_data_oe_n,
      .bus_data_wdata, .bus_data_wr(stb[0]), .bus_data_rd(stb[1]),
      .bus_data_reg, .flag_clear(stb[2]), .addr_match_flag,
      .rx_buffer_full_flag, .read_dir_flag, .tx_buffer_full_flag,
      .stop_flag, .overflow_flag
   );
   i2c_master_model m (.sda(port_pin_data_i), .scl_low, .sda_low);
   always #5 core_clk = ~core_clk;
   task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic e, input logic g);
      chk_byte({7'h0, e}, {7'h0, g});
   endtask
   // Ends off the edge so flags are sampled once settled
   task automatic pulse(input logic [2:0] s);
      @(posedge core_clk) stb <= s;
      @(posedge core_clk) stb <= 3'h0;
      @(negedge core_clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      fail_count++;
      summarize();
   end
   initial
   begin
      logic [7:0] d, q;
      logic a;
      void'($urandom(32'h9F77A088));
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (16)
      begin
         @(posedge core_clk);
         {pu, sw} <= 8'($urandom);
         power_down <= 1'($urandom);
         @(negedge core_clk);
         chk_flag(pu[0] & pu[1], pullup_en_clk);
         chk_flag(pu[2] & pu[3], pullup_en_dat);
         chk_byte({4'h0, ~sw[2], sw[3], ~sw[0], sw[1]}, {4'h0,
            port_pin_data_oe_n, port_pin_data_o, port_pin_clock_oe_n,
            port_pin_clock_o});
      end
      $display("test idle pins done");
      @(posedge core_clk);
      {pu, sw} <= 8'hF0;
      power_down <= 1'b0;
      // Released pins settle first, so enabling shows no false stop
      repeat (3) @(posedge core_clk);
      serial_bus_enable <= 1'b1;
      pulse(3'b000);
      chk_flag(1'b1, port_pin_data_oe_n);
      m.start_cond();
      m.xfer(8'h6C, 1'b0, q, a);
      chk_flag(1'b1, a);
      chk_flag(1'b1, addr_match_flag);
      for (int i = 0; i < 3; i++)
      begin
         d = 8'($urandom);
         rxq.push_back(d);
         m.xfer(d, 1'b0, q, a);
         chk_flag(1'b1, a);
         chk_flag(1'b1, rx_buffer_full_flag);
         chk_flag(rxq.size() > 1, overflow_flag);
         chk_byte(rxq[$], bus_data_reg);
         if (i == 0)
         begin
            pulse(3'b010);
            rxq.delete();
            chk_flag(1'b0, rx_buffer_full_flag);
         end
      end
      chk_flag(1'b0, stop_flag);
      m.stop_cond();
      repeat (10) @(negedge core_clk);
      chk_flag(1'b1, stop_flag);
      $display("test write done");
      pulse(3'b110);
      rxq.delete();
      chk_flag(1'b0, stop_flag);
      for (int k = 0; k < 2; k++)
      begin
         // Let the last stop reach the flags before the mode moves
         repeat (4) @(posedge core_clk);
         power_down <= k[0];
         m.start_cond();
         m.xfer(k ? 8'h6C : {7'($urandom_range(1, 53)), 1'b0}, 1'b0, q, a);
         chk_flag(1'b0, a);
         m.xfer(8'h6C, 1'b0, q, a);
         chk_flag(1'b0, a);
         m.stop_cond();
         chk_flag(1'b0, addr_match_flag);
      end
      $display("test refused address done");
      repeat (4) @(posedge core_clk);
      power_down <= 1'b0;
      general_call_enable <= 1'b1;
      @(posedge core_clk);
      m.start_cond();
      m.xfer(8'h00, 1'b0, q, a);
      chk_flag(1'b1, a);
      m.stop_cond();
      chk_flag(1'b1, addr_match_flag);
      chk_flag(1'b0, read_dir_flag);
      $display("test general call done");
      for (int k = 0; k < 2; k++)
      begin
         d = 8'($urandom);
         // One-deep model buffer: a byte written while full is dropped
         if (txq.size() == 0)
            txq.push_back(d);
         @(posedge core_clk) bus_data_wdata <= d;
         pulse(3'b001);
         chk_flag(1'b1, tx_buffer_full_flag);
         chk_flag(k == 1, overflow_flag);
      end
      m.start_cond();
      m.xfer(8'h6D, 1'b0, q, a);
      chk_flag(1'b1, a);
      chk_flag(1'b1, read_dir_flag);
      m.xfer(8'hFF, 1'b0, q, a);
      chk_byte(txq.pop_front(), q);
      chk_flag(1'b0, tx_buffer_full_flag);
      m.stop_cond();
      repeat (10) @(negedge core_clk);
      $display("test read done");
      summarize();
   end
endmodule // tb_i2c_slave_port
`default_nettype wire
